// ### verilog/vic_pkg.sv
// Purpose: Shared constants and types for the vectored interrupt control
// Assumes: 16-bit core addresses, APB register word per offset
// Notes:   Offsets are byte addresses on an 8-bit APB address
package vic_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Register byte offsets
   localparam logic [7:0]  ADDR_ENABLE  = 8'h00;
   localparam logic [7:0]  ADDR_PENDING = 8'h04;
   localparam logic [7:0]  ADDR_COND    = 8'h08;
   localparam logic [7:0]  ADDR_AUXCFG  = 8'h0C;
   localparam logic [7:0]  ADDR_PSW     = 8'h10;
   localparam logic [7:0]  ADDR_SP      = 8'h14;
   localparam logic [7:0]  ADDR_PC      = 8'h18;
   localparam logic [7:0]  ADDR_EVSTAT  = 8'h1C;
   localparam logic [7:0]  ADDR_EVMASK  = 8'h20;

   ////////////////////////////////////////////////////////////////////////
   // Source ranks, also bit positions in pending and enable
   localparam int SRC_RESET = 0;
   localparam int SRC_NMI   = 1;
   localparam int SRC_EA    = 2;
   localparam int SRC_EB    = 3;
   localparam int SRC_EC    = 4;
   localparam int SRC_TMR   = 5;
   localparam int SRC_SER   = 6;
   localparam int SRC_ADC   = 7;
   localparam int BIT_GIE   = 0;
   localparam int BIT_AUXEN = 0;
   localparam int BIT_AUXPD = 1;
   localparam int BIT_SAVED = 0;
   localparam int EV_ACK    = 0;
   localparam int EV_RET    = 1;
   localparam int NUM_PINS  = 5;

   ////////////////////////////////////////////////////////////////////////
   // Reset values and addresses
   localparam logic [7:0]  ENABLE_RST   = 8'h00;
   localparam logic [7:0]  PENDING_RST  = 8'h00;
   localparam logic [2:0]  COND_RST     = 3'h0;
   localparam logic [1:0]  AUXCFG_RST   = 2'h0;
   localparam logic [15:0] SP_RST       = 16'h0000;
   localparam logic [15:0] PC_RST       = 16'h0000;
   localparam logic [15:0] RESET_VECTOR = 16'hFFFE;
   localparam logic [15:0] VECTOR_BASE  = 16'hFFFE;
   localparam logic [15:0] SP_STEP      = 16'h0002;
   localparam logic [1:0]  EV_RST       = 2'h0;

   ////////////////////////////////////////////////////////////////////////
   // Sequencer states
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_RSTV = 3'b001,
      ST_PUSH = 3'b010,
      ST_VEC  = 3'b011,
      ST_POP  = 3'b100
   } vic_state_e;

   // Memory request towards the core bus
   typedef struct packed {
      logic        req;
      logic        we;
      logic [15:0] addr;
      logic [15:0] wdata;
   } vic_mem_s;

   localparam vic_mem_s MEM_IDLE = '{req: 1'b0, we: 1'b0,
                                     addr: 16'h0000, wdata: 16'h0000};

endpackage

// ### verilog/vic_edge_sync.sv
// Purpose: Pin synchroniser with selectable edge detection
// Assumes: pin is asynchronous to pclk
// Notes:   pol high selects rising edge, low selects falling edge
`timescale 1ns/100ps
module vic_edge_sync (
   // Clock and reset
   input  wire logic pclk,
   input  wire logic presetn,
   // Pin and edge choice
   input  wire logic pin,
   input  wire logic pol,
   // Synchronised level and edge pulse
   output logic      level,
   output logic      edge_pulse
);

   logic       meta_reg;
   logic       sync_reg;
   logic       last_reg;
   logic [1:0] fill_reg;

   ////////////////////////////////////////////////////////////////////////
   // Two-stage synchroniser, then history
   // Level reads inactive high, edges masked until the chain is filled
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_reg <= 1'b1;
         sync_reg <= 1'b1;
         last_reg <= 1'b1;
         fill_reg <= 2'h0;
      end else begin
         meta_reg <= pin;
         sync_reg <= meta_reg;
         last_reg <= sync_reg;
         if (fill_reg != 2'h3) begin
            fill_reg <= fill_reg + 2'h1;
         end
      end
   end

   assign level      = sync_reg;
   assign edge_pulse = (fill_reg == 2'h3) &
                       (pol ? (sync_reg & ~last_reg) : (~sync_reg & last_reg));

endmodule

// ### verilog/vic_top.sv
// Purpose: Vectored interrupt control with acknowledge and return sequencer
// Assumes: core pulses instr_done at instruction end; memory acks once
// Notes:   APB slave, zero wait states, status word and stack pointer here
//
// Implementation choices: the register offsets and the APB interface to the registers.
`timescale 1ns/100ps
module vic_top (
   // Clock and reset
   input  wire logic             pclk,
   input  wire logic             presetn,
   // APB slave
   input  wire logic             psel,
   input  wire logic             penable,
   input  wire logic             pwrite,
   input  wire logic [7:0]       paddr,
   input  wire logic [31:0]      pwdata,
   output logic                  pready,
   output logic                  pslverr,
   output logic      [31:0]      prdata,
   // External interrupt pins
   input  wire logic             nmi_pin,
   input  wire logic             edge_int_in_a,
   input  wire logic             edge_int_in_b,
   input  wire logic             edge_int_in_c,
   input  wire logic             aux_level_interrupt_n,
   // On-chip peripheral request pulses
   input  wire logic             timer_ovf_evt,
   input  wire logic             serial_evt,
   input  wire logic             adc_evt,
   // Core side
   input  wire logic             instr_done,
   input  wire logic             ret_done,
   input  wire logic             return_from_interrupt_instr_done,
   input  wire logic [15:0]      cur_pc,
   output logic                  core_hold,
   output logic                  pc_load,
   output logic      [15:0]      pc_value,
   // Memory bus request
   output vic_pkg::vic_mem_s     mem_o,
   input  wire logic             mem_ack,
   input  wire logic [15:0]      mem_rdata,
   // Pin float control and interrupt
   output logic                  pins_hiz,
   output logic                  irq
);

   vic_pkg::vic_state_e state_reg, state_next;
   vic_pkg::vic_mem_s   mem_next;
   logic [7:0]  enable_reg, pending_reg, pending_next, pend_set, pend_clr;
   logic [2:0]  cond_reg;
   logic [1:0]  auxcfg_reg, evstat_reg, evmask_reg, ev_set;
   logic        saved_reg, is_return_from_interrupt_instr_reg, hiz_reg;
   logic [15:0] sp_reg, pc_reg, push_pc_reg;
   logic [2:0]  src_reg, src_next;
   localparam int NUM_PINS = vic_pkg::NUM_PINS;
   logic [7:0]  req;
   logic        any_req, aux_req;
   logic [NUM_PINS-1:0] pin_vec, pol_vec, lvl_vec, edge_vec;
   logic        setup, wr, rd;
   logic [31:0] rdata_next;
   logic        err_next;
   logic        ack_done, pop_done;

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   assign pin_vec = {aux_level_interrupt_n, edge_int_in_c, edge_int_in_b,
                     edge_int_in_a, nmi_pin};
   assign pol_vec = {1'b0, cond_reg, 1'b1};

   genvar gi;
   generate
      for (gi = 0; gi < NUM_PINS; gi++) begin : g_pin
         vic_edge_sync u_sync (
            .pclk       (pclk),
            .presetn    (presetn),
            .pin        (pin_vec[gi]),
            .pol        (pol_vec[gi]),
            .level      (lvl_vec[gi]),
            .edge_pulse (edge_vec[gi])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // APB decode
   assign setup  = psel & ~penable;
   assign wr     = psel & penable & pwrite;
   assign rd     = psel & penable & ~pwrite;
   assign pready = 1'b1;

   always_comb begin
      rdata_next = 32'h0000_0000;
      err_next   = 1'b0;
      if (paddr == vic_pkg::ADDR_ENABLE) begin
         rdata_next[7:0] = enable_reg;
      end else if (paddr == vic_pkg::ADDR_PENDING) begin
         rdata_next[7:0] = pending_reg;
      end else if (paddr == vic_pkg::ADDR_COND) begin
         rdata_next[2:0] = cond_reg;
      end else if (paddr == vic_pkg::ADDR_AUXCFG) begin
         rdata_next[1:0] = auxcfg_reg;
      end else if (paddr == vic_pkg::ADDR_PSW) begin
         rdata_next[0] = saved_reg;
      end else if (paddr == vic_pkg::ADDR_SP) begin
         rdata_next[15:0] = sp_reg;
      end else if (paddr == vic_pkg::ADDR_PC) begin
         rdata_next[15:0] = pc_reg;
      end else if (paddr == vic_pkg::ADDR_EVSTAT) begin
         rdata_next[1:0] = evstat_reg;
      end else if (paddr == vic_pkg::ADDR_EVMASK) begin
         rdata_next[1:0] = evmask_reg;
      end else begin
         err_next = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else if (setup) begin
         prdata  <= pwrite ? 32'h0000_0000 : rdata_next;
         pslverr <= err_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Request logic
   assign aux_req = auxcfg_reg[vic_pkg::BIT_AUXEN] &
                    auxcfg_reg[vic_pkg::BIT_AUXPD];
   always_comb begin
      req = 8'h00;
      req[vic_pkg::SRC_NMI] = pending_reg[vic_pkg::SRC_NMI];
      for (int i = vic_pkg::SRC_EA; i <= vic_pkg::SRC_ADC; i++) begin
         req[i] = enable_reg[vic_pkg::BIT_GIE] & enable_reg[i] &
                  pending_reg[i];
      end
      req[vic_pkg::SRC_SER] = req[vic_pkg::SRC_SER] |
                              (enable_reg[vic_pkg::BIT_GIE] & aux_req);
   end
   assign any_req = |req;

   always_comb begin
      src_next = src_reg;
      for (int i = vic_pkg::SRC_ADC; i >= vic_pkg::SRC_NMI; i--) begin
         if (req[i]) begin
            src_next = 3'(i);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Sequencer
   assign ack_done = (state_reg == vic_pkg::ST_PUSH) & mem_ack;
   assign pop_done = (state_reg == vic_pkg::ST_POP) & mem_ack;

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         vic_pkg::ST_RSTV: begin
            if (mem_ack) begin
               state_next = vic_pkg::ST_IDLE;
            end
         end
         vic_pkg::ST_IDLE: begin
            if (ret_done | return_from_interrupt_instr_done) begin
               state_next = vic_pkg::ST_POP;
            end else if (instr_done & any_req) begin
               state_next = vic_pkg::ST_PUSH;
            end
         end
         vic_pkg::ST_PUSH: begin
            if (mem_ack) begin
               state_next = vic_pkg::ST_VEC;
            end
         end
         vic_pkg::ST_VEC, vic_pkg::ST_POP: begin
            if (mem_ack) begin
               state_next = vic_pkg::ST_IDLE;
            end
         end
         default: state_next = vic_pkg::ST_IDLE;
      endcase
   end

   always_comb begin
      mem_next = vic_pkg::MEM_IDLE;
      case (state_next)
         vic_pkg::ST_RSTV: begin
            mem_next.req  = 1'b1;
            mem_next.addr = vic_pkg::RESET_VECTOR;
         end
         vic_pkg::ST_PUSH: begin
            mem_next.req   = 1'b1;
            mem_next.we    = 1'b1;
            mem_next.addr  = sp_reg;
            mem_next.wdata = (state_reg == vic_pkg::ST_IDLE) ? cur_pc
                                                            : push_pc_reg;
         end
         vic_pkg::ST_VEC: begin
            mem_next.req  = 1'b1;
            mem_next.addr = vic_pkg::VECTOR_BASE -
                            {12'h000, src_reg, 1'b0};
         end
         vic_pkg::ST_POP: begin
            mem_next.req  = 1'b1;
            mem_next.addr = sp_reg - vic_pkg::SP_STEP;
         end
         default: mem_next = vic_pkg::MEM_IDLE;
      endcase
      if (mem_ack) begin
         mem_next.req = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= vic_pkg::ST_RSTV;
         mem_o     <= vic_pkg::MEM_IDLE;
      end else begin
         state_reg <= state_next;
         mem_o     <= mem_next;
         if (state_reg != state_next) begin
            mem_o.req <= mem_next.req | (state_next != vic_pkg::ST_IDLE);
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         src_reg     <= 3'h0;
         push_pc_reg <= vic_pkg::PC_RST;
         is_return_from_interrupt_instr_reg <= 1'b0;
      end else if (state_reg == vic_pkg::ST_IDLE) begin
         src_reg     <= src_next;
         push_pc_reg <= cur_pc;
         is_return_from_interrupt_instr_reg <= return_from_interrupt_instr_done;
      end
   end

   // PC load towards the core
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pc_reg  <= vic_pkg::PC_RST;
         pc_load <= 1'b0;
      end else begin
         pc_load <= mem_ack & (state_reg == vic_pkg::ST_RSTV |
                               state_reg == vic_pkg::ST_VEC |
                               state_reg == vic_pkg::ST_POP);
         if (mem_ack & state_reg != vic_pkg::ST_PUSH &
             state_reg != vic_pkg::ST_IDLE) begin
            pc_reg <= mem_rdata;
         end
      end
   end
   assign pc_value  = pc_reg;
   assign core_hold = (state_reg != vic_pkg::ST_IDLE);

   // Stack pointer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sp_reg <= vic_pkg::SP_RST;
      end else if (ack_done) begin
         sp_reg <= sp_reg + vic_pkg::SP_STEP;
      end else if (pop_done) begin
         sp_reg <= sp_reg - vic_pkg::SP_STEP;
      end else if (wr & paddr == vic_pkg::ADDR_SP) begin
         sp_reg <= pwdata[15:0];
      end
   end

   // Enables, global enable and saved copy
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         enable_reg <= vic_pkg::ENABLE_RST;
         saved_reg  <= 1'b0;
      end else begin
         if (wr & paddr == vic_pkg::ADDR_ENABLE) begin
            enable_reg <= pwdata[7:0] & 8'hFD;
         end
         if (wr & paddr == vic_pkg::ADDR_PSW) begin
            saved_reg <= pwdata[vic_pkg::BIT_SAVED];
         end
         if (ack_done) begin
            saved_reg <= enable_reg[vic_pkg::BIT_GIE];
            enable_reg[vic_pkg::BIT_GIE] <= 1'b0;
         end else if (pop_done & is_return_from_interrupt_instr_reg & saved_reg) begin
            enable_reg[vic_pkg::BIT_GIE] <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Pending flags
   always_comb begin
      pend_set = 8'h00;
      pend_clr = 8'h00;
      pend_set[vic_pkg::SRC_NMI] = edge_vec[0];
      pend_set[vic_pkg::SRC_EA]  = edge_vec[1];
      pend_set[vic_pkg::SRC_EB]  = edge_vec[2];
      pend_set[vic_pkg::SRC_EC]  = edge_vec[3];
      pend_set[vic_pkg::SRC_TMR] = timer_ovf_evt;
      pend_set[vic_pkg::SRC_SER] = serial_evt;
      pend_set[vic_pkg::SRC_ADC] = adc_evt;
      if (wr & paddr == vic_pkg::ADDR_PENDING) begin
         pend_clr[4:2] = ~pwdata[4:2];
         pend_clr[7:5] = ~pwdata[7:5];
         pend_set[7:5] = pend_set[7:5] | pwdata[7:5];
      end
      if (ack_done & src_reg <= 3'(vic_pkg::SRC_EC)) begin
         pend_clr[src_reg] = 1'b1;
      end
      pending_next = (pending_reg & ~pend_clr) | pend_set;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pending_reg <= vic_pkg::PENDING_RST;
         cond_reg    <= vic_pkg::COND_RST;
      end else begin
         pending_reg <= pending_next;
         if (wr & paddr == vic_pkg::ADDR_COND) begin
            cond_reg <= pwdata[2:0];
         end
      end
   end

   // Aux level input: own enable and pending bits
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         auxcfg_reg <= vic_pkg::AUXCFG_RST;
      end else begin
         if (wr & paddr == vic_pkg::ADDR_AUXCFG) begin
            auxcfg_reg[vic_pkg::BIT_AUXEN] <= pwdata[vic_pkg::BIT_AUXEN];
            auxcfg_reg[vic_pkg::BIT_AUXPD] <= pwdata[vic_pkg::BIT_AUXPD] &
                                              auxcfg_reg[vic_pkg::BIT_AUXPD];
         end
         if (~lvl_vec[4]) begin
            auxcfg_reg[vic_pkg::BIT_AUXPD] <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Event status, mask, interrupt line
   assign ev_set = {pop_done, ack_done};
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         evstat_reg <= vic_pkg::EV_RST;
         evmask_reg <= vic_pkg::EV_RST;
      end else begin
         if (rd & paddr == vic_pkg::ADDR_EVSTAT) begin
            evstat_reg <= ev_set;
         end else begin
            evstat_reg <= evstat_reg | ev_set;
         end
         if (wr & paddr == vic_pkg::ADDR_EVMASK) begin
            evmask_reg <= pwdata[1:0];
         end
      end
   end
   assign irq = |(evstat_reg & evmask_reg);

   // Pin float during reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hiz_reg <= 1'b1;
      end else begin
         hiz_reg <= 1'b0;
      end
   end
   assign pins_hiz = hiz_reg | ~presetn;

   ////////////////////////////////////////////////////////////////////////
   // Assertions
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_sp_push_step: assert property (ack_done |=>
      sp_reg == $past(sp_reg) + vic_pkg::SP_STEP) else $error("sp step");
   a_gie_save: assert property (ack_done |=>
      !enable_reg[0] && saved_reg == $past(enable_reg[0]))
      else $error("gie save");
   a_vector_addr: assert property (
      state_reg == vic_pkg::ST_PUSH && mem_ack |=> mem_o.req &&
      mem_o.addr == vic_pkg::VECTOR_BASE - {12'h000, src_reg, 1'b0})
      else $error("vector addr");
   a_return_from_interrupt_instr_restore: assert property (
      pop_done && is_return_from_interrupt_instr_reg && saved_reg |=> enable_reg[0])
      else $error("return_from_interrupt_instr gie");
   a_edge_autoclr: assert property (
      ack_done && src_reg == 3'(vic_pkg::SRC_EA) && !edge_vec[1]
      |=> !pending_reg[vic_pkg::SRC_EA]) else $error("auto clear");
   a_nmi_readonly: assert property (
      wr && paddr == vic_pkg::ADDR_PENDING && !ack_done |=>
      pending_reg[1] == ($past(pending_reg[1]) | $past(edge_vec[0])))
      else $error("nmi ro");
   a_set_disabled: assert property (timer_ovf_evt |=>
      pending_reg[vic_pkg::SRC_TMR]) else $error("pend set");
   a_periph_hold: assert property (
      pending_reg[vic_pkg::SRC_TMR] && !wr |=>
      pending_reg[vic_pkg::SRC_TMR]) else $error("periph hold");
   a_boundary_only: assert property (
      state_reg == vic_pkg::ST_IDLE && !instr_done |=>
      state_reg != vic_pkg::ST_PUSH) else $error("boundary");
   a_global_gate: assert property (
      state_reg == vic_pkg::ST_IDLE && !enable_reg[0] && !pending_reg[1]
      && !ret_done && !return_from_interrupt_instr_done |=> state_reg == vic_pkg::ST_IDLE)
      else $error("gie gate");
   a_rank_nmi: assert property (
      state_reg == vic_pkg::ST_IDLE && instr_done && req[1] &&
      !ret_done && !return_from_interrupt_instr_done |=> src_reg == 3'(vic_pkg::SRC_NMI))
      else $error("rank");
   a_aux_gate: assert property (!auxcfg_reg[0] |-> !aux_req)
      else $error("aux gate");

   c_ack:    cover property (ack_done ##[1:20] pc_load);
   c_return_from_interrupt_instr:   cover property (pop_done && is_return_from_interrupt_instr_reg && saved_reg);
   c_nested: cover property (ack_done ##[1:50] ack_done);
   c_aux:    cover property (aux_req ##[1:20] ack_done);

endmodule

// ### verif/vic_mem_model.sv
// Purpose: Core memory partner answering the sequencer requests
// Assumes: one request at a time, req held until ack
// Notes:   read data is address xor 5A5A, slow adds wait cycles
`timescale 1ns/100ps
module vic_mem_model (
   // Clock and reset
   input  wire logic          pclk,
   input  wire logic          presetn,
   // Request side
   input  wire vic_pkg::vic_mem_s mem_o,
   input  wire logic          slow,
   output logic               mem_ack,
   output logic [15:0]        mem_rdata,
   // Last write seen
   output logic [15:0]        wr_addr,
   output logic [15:0]        wr_data
);
   logic [2:0] cnt;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mem_ack   <= 1'b0;
         cnt       <= 3'h0;
         mem_rdata <= 16'hFFFF;
         wr_addr   <= 16'h0000;
         wr_data   <= 16'h0000;
      end else if (mem_ack) begin
         mem_ack   <= 1'b0;
         cnt       <= 3'h0;
         mem_rdata <= ~mem_rdata;
      end else if (mem_o.req && cnt >= (slow ? 3'h4 : 3'h0)) begin
         mem_ack   <= 1'b1;
         mem_rdata <= mem_o.addr ^ 16'h5A5A;
         if (mem_o.we) begin
            wr_addr <= mem_o.addr;
            wr_data <= mem_o.wdata;
         end
      end else begin
         cnt       <= cnt + {2'b00, mem_o.req};
         mem_rdata <= ~mem_rdata;
      end
   end
endmodule

// ### verif/vic_top_test.sv
// Purpose: Self-checking bench for the vectored interrupt control
// Assumes: zero wait APB, memory partner in its own module
// Notes:   expected values come from a small integer model
`timescale 1ns/100ps
module vic_top_test;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000, prdata, rdat;
   logic pready, pslverr, rerr, nmi = 0, ea = 1, eb = 1, ec = 1, aux_n = 1;
   logic tmr = 0, ser = 0, adc = 0, idone = 0, ret = 0, return_from_interrupt_instr = 0, slow = 0;
   logic [15:0] cur_pc = 16'h0000, pc_value, wa, wd, rdm;
   logic core_hold, pc_load, ack, pins_hiz, irq;
   vic_pkg::vic_mem_s mem_o;
   int n_fail = 0, n_checks = 0, sp_m = 0;
   always #12.5 pclk = ~pclk;
   vic_top dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pready(pready), .pslverr(pslverr), .prdata(prdata), .nmi_pin(nmi),
      .edge_int_in_a(ea), .edge_int_in_b(eb), .edge_int_in_c(ec),
      .aux_level_interrupt_n(aux_n), .timer_ovf_evt(tmr), .serial_evt(ser),
      .adc_evt(adc), .instr_done(idone), .ret_done(ret), .return_from_interrupt_instr_done(return_from_interrupt_instr),
      .cur_pc(cur_pc), .core_hold(core_hold), .pc_load(pc_load),
      .pc_value(pc_value), .mem_o(mem_o), .mem_ack(ack), .mem_rdata(rdm),
      .pins_hiz(pins_hiz), .irq(irq));
   vic_mem_model mem (.pclk(pclk), .presetn(presetn), .mem_o(mem_o),
      .slow(slow), .mem_ack(ack), .mem_rdata(rdm), .wr_addr(wa),
      .wr_data(wd));
   ////////////////////////////////////////////////////////////////////////
   task automatic conclude;
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
      int i;
      @(posedge pclk);
      psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      i = 0;
      do begin
         @(posedge pclk);
         i++;
      end while (pready !== 1'b1 && i < 50);
      if (i >= 50) begin n_fail++; conclude(); end
      rdat = prdata;
      rerr = pslverr;
      psel <= 0; penable <= 0;
   endtask
   task automatic rd(logic [7:0] a, logic [31:0] e, string nm);
      apb(0, a, 32'h0000_0000);
      chk(nm, rdat, e);
   endtask
   task automatic wait_pc(logic [15:0] vec);
      int i;
      for (i = 0; i < 100 && pc_load !== 1'b1; i++) @(negedge pclk);
      if (i >= 100) begin n_fail++; conclude(); end
      chk("pc_value", {16'h0000, pc_value}, {16'h0000, vec ^ 16'h5A5A});
   endtask
   task automatic take(logic [15:0] vec);
      @(posedge pclk);
      cur_pc <= 16'($urandom); idone <= 1;
      @(posedge pclk);
      idone <= 0;
      wait_pc(vec);
      chk("push addr", {16'h0000, wa}, sp_m);
      chk("push data", {16'h0000, wd}, {16'h0000, cur_pc});
      sp_m += 2;
      rd(vic_pkg::ADDR_SP, sp_m, "sp");
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(34721));
      repeat (16) @(posedge pclk);
      chk("pins_hiz", pins_hiz, 1'b1);
      presetn <= 1;
      wait_pc(16'hFFFE);
      chk("pins_hiz low", pins_hiz, 1'b0);
      rd(8'h40, 0, "unmapped");
      chk("pslverr", rerr, 1'b1);
      apb(1, vic_pkg::ADDR_EVMASK, 32'h0000_0001);
      @(posedge pclk) tmr <= 1;
      @(posedge pclk) tmr <= 0;
      rd(vic_pkg::ADDR_PENDING, 32'h0000_0020, "tmr pend");
      apb(1, vic_pkg::ADDR_PENDING, 32'h0000_0000);
      rd(vic_pkg::ADDR_PENDING, 0, "sw clear");
      @(posedge pclk) nmi <= 1; ea <= 0;
      repeat (6) @(posedge pclk);
      rd(vic_pkg::ADDR_PENDING, 32'h0000_0006, "fall a");
      apb(1, vic_pkg::ADDR_PENDING, 32'h0000_0000);
      rd(vic_pkg::ADDR_PENDING, 32'h0000_0002, "nmi ro");
      apb(1, vic_pkg::ADDR_COND, 32'h0000_0001);
      @(posedge pclk) ea <= 1;
      repeat (6) @(posedge pclk);
      apb(1, vic_pkg::ADDR_PENDING, 32'h0000_001F);
      rd(vic_pkg::ADDR_PENDING, 32'h0000_0006, "rise a");
      apb(1, vic_pkg::ADDR_ENABLE, 32'h0000_0005);
      take(16'hFFFC);
      chk("irq", irq, 1'b1);
      rd(vic_pkg::ADDR_EVSTAT, 1, "evstat");
      @(negedge pclk);
      chk("irq clr", irq, 1'b0);
      rd(vic_pkg::ADDR_PSW, 1, "saved");
      rd(vic_pkg::ADDR_ENABLE, 32'h0000_0004, "gie off");
      rd(vic_pkg::ADDR_PENDING, 32'h0000_0004, "nmi done");
      @(posedge pclk) idone <= 1;
      @(posedge pclk) idone <= 0;
      repeat (4) @(negedge pclk);
      chk("no take", core_hold, 1'b0);
      @(posedge pclk) return_from_interrupt_instr <= 1;
      @(posedge pclk) return_from_interrupt_instr <= 0;
      wait_pc(16'(sp_m - 2));
      sp_m -= 2;
      rd(vic_pkg::ADDR_ENABLE, 32'h0000_0005, "return_from_interrupt_instr gie");
      take(16'hFFFA);
      rd(vic_pkg::ADDR_PENDING, 0, "auto clr");
      apb(1, vic_pkg::ADDR_ENABLE, 32'h0000_0025);
      @(posedge pclk) tmr <= 1; slow <= 1;
      @(posedge pclk) tmr <= 0;
      take(16'hFFF4);
      @(posedge pclk) ret <= 1;
      @(posedge pclk) ret <= 0;
      wait_pc(16'(sp_m - 2));
      sp_m -= 2;
      rd(vic_pkg::ADDR_ENABLE, 32'h0000_0024, "ret only");
      @(posedge pclk) aux_n <= 0;
      repeat (6) @(posedge pclk);
      rd(vic_pkg::ADDR_AUXCFG, 32'h0000_0002, "aux pend");
      conclude();
   end
endmodule
